// ===== strobe_gen.sv
`timescale 1ns/10ps
`default_nettype none
module strobe_gen
  import trig_io_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  strobe_if.gen sb
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_ACTIVE = 2'b10
  } stb_state_e;

  stb_state_e state_q;
  logic [STB_W-1:0] cnt_q;
  logic frame_match;
  logic fire;

  assign frame_match = (sb.mode[0] & ~sb.frame_b) | (sb.mode[1] & sb.frame_b); // R15
  assign fire = frame_match & (sb.ref_readout ? sb.read_start : sb.exp_start); // R16

  // references arriving mid-strobe are ignored so a pulse is never cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (fire) begin
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (cnt_q >= sb.delay) begin // R17
            cnt_q <= '0;
            state_q <= (sb.width == '0) ? ST_IDLE : ST_ACTIVE;
          end else if (sb.us_tick) begin // R21
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_ACTIVE: begin
          if (cnt_q >= sb.width) begin // R17
            cnt_q <= '0;
            state_q <= ST_IDLE;
          end else if (sb.us_tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  assign sb.strobe = (state_q == ST_ACTIVE);
endmodule : strobe_gen
`default_nettype wire

// ===== strobe_if.sv
`timescale 1ns/10ps
`default_nettype none
interface strobe_if;
  import trig_io_pkg::*;
  logic [1:0] mode;
  logic ref_readout;
  logic [STB_W-1:0] delay;
  logic [STB_W-1:0] width;
  logic us_tick;
  logic exp_start;
  logic read_start;
  logic frame_b;
  logic strobe;
  modport ctrl (
    output mode, ref_readout, delay, width, us_tick, exp_start,
    output read_start, frame_b,
    input strobe
  );
  modport gen (
    input mode, ref_readout, delay, width, us_tick, exp_start,
    input read_start, frame_b,
    output strobe
  );
endinterface : strobe_if
`default_nettype wire

// ===== trig_io_pkg.sv
// Overview of operation
// R1: pick one trigger source of six
// R2: trigger on chosen rising or falling edge
// R3: debounce choices off through ten milliseconds
// R4: debounce resets to 100 microseconds
// R5: ringing on an edge gives one trigger
// R6: triggers act only while trigger enabled
// R7: software trigger only when software selected
// R8: pulse counters scaled by 1x to 1000x
// R9: pulse period programmed in microsecond units
// R10: pulse width programmed in microsecond units
// R11: continuous mode runs until stopped
// R12: counted mode emits 1..65500 pulses, halts
// R13: one control starts idle, stops running
// R14: status shows running or on hold
// R15: strobe off, frame A, B or both
// R16: strobe referenced to exposure or readout
// R17: strobe delay and width 0..1000000 us
// R18: each output maps one of five sources
// R19: each output has its own polarity
// R20: pulse asserted from period start for width
// R21: timing from microsecond tick, debounce holds level
`default_nettype none
package trig_io_pkg;
  localparam int CLK_FREQ_MHZ = 250;
  localparam int TICK_TIME_NS = 1000;
  localparam int US_TICK_CYCLES = TICK_TIME_NS * CLK_FREQ_MHZ / 1000;
  localparam int PG_WIDTH_BITS = 24;
  localparam int STB_W = 20;
  localparam logic [15:0] PG_MAX_COUNT = 16'd65500;

  localparam logic [11:0] OFS_TRIG_CTRL = 12'h000;
  localparam logic [11:0] OFS_COMMAND = 12'h004;
  localparam logic [11:0] OFS_PG_CFG = 12'h008;
  localparam logic [11:0] OFS_PG_PERIOD = 12'h00c;
  localparam logic [11:0] OFS_PG_WIDTH = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_STB_BASE = 12'h018;
  localparam logic [11:0] OFS_STB_STEP = 12'h00c;
  localparam logic [11:0] OFS_OUT_MAP = 12'h030;

  // trigger control fields
  localparam int TC_EN = 0;
  localparam int TC_SRC = 1;
  localparam int TC_FALL = 4;
  localparam int TC_DB = 5;
  localparam int TC_DUAL = 8;
  // command fields, write-only strobes
  localparam int CMD_SW = 0;
  localparam int CMD_PG_TOGGLE = 1;
  // pulse generator config fields
  localparam int PG_GRAN = 0;
  localparam int PG_COUNTED = 2;
  localparam int PG_COUNT = 16;
  // strobe config fields, delay and width at +4 and +8
  localparam int SC_MODE = 0;
  localparam int SC_READOUT = 2;
  // output map fields, four bits per output
  localparam int OM_STEP = 4;
  localparam int OM_POL = 3;

  typedef enum logic [2:0] {
    SRC_IN1 = 3'b000,
    SRC_IN2 = 3'b001,
    SRC_CC1 = 3'b010,
    SRC_CC2 = 3'b011,
    SRC_SW = 3'b100,
    SRC_PG = 3'b101
  } trig_src_e;

  typedef enum logic [2:0] {
    MAP_NONE = 3'b000,
    MAP_MIRROR = 3'b001,
    MAP_PG = 3'b010,
    MAP_STB1 = 3'b011,
    MAP_STB2 = 3'b100
  } out_map_e;

  localparam logic [2:0] DB_OFF = 3'd0;
  localparam logic [2:0] DB_RESET_SEL = 3'd3;
  localparam logic [13:0] DB_10US = 14'd10;
  localparam logic [13:0] DB_50US = 14'd50;
  localparam logic [13:0] DB_100US = 14'd100;
  localparam logic [13:0] DB_500US = 14'd500;
  localparam logic [13:0] DB_1MS_US = 14'd1000;
  localparam logic [13:0] DB_5MS_US = 14'd5000;
  localparam logic [13:0] DB_10MS_US = 14'd10000;

  function automatic logic [13:0] db_limit(input logic [2:0] s);
    case (s)
      3'd1: db_limit = DB_10US;
      3'd2: db_limit = DB_50US;
      3'd3: db_limit = DB_100US;
      3'd4: db_limit = DB_500US;
      3'd5: db_limit = DB_1MS_US;
      3'd6: db_limit = DB_5MS_US;
      3'd7: db_limit = DB_10MS_US;
      default: db_limit = 14'd0;
    endcase
  endfunction : db_limit

  function automatic logic [9:0] gran_div(input logic [1:0] g);
    case (g)
      2'd0: gran_div = 10'd1;
      2'd1: gran_div = 10'd10;
      2'd2: gran_div = 10'd100;
      default: gran_div = 10'd1000;
    endcase
  endfunction : gran_div
endpackage : trig_io_pkg
`default_nettype wire

// ===== trig_partner.sv
`timescale 1ns/10ps
`default_nettype none
module trig_partner (
  input wire logic pclk,
  output logic ext_trigger_input_one,
  output logic ext_trigger_input_two,
  output logic grabber_control_line_one,
  output logic grabber_control_line_two,
  output logic frame_exposure_start,
  output logic frame_readout_start,
  output logic frame_is_b
);
  logic [3:0] pins_q;
  assign ext_trigger_input_one = pins_q[0];
  assign ext_trigger_input_two = pins_q[1];
  assign grabber_control_line_one = pins_q[2];
  assign grabber_control_line_two = pins_q[3];
  initial begin
    pins_q = 4'h0;
    frame_exposure_start = 1'b0;
    frame_readout_start = 1'b0;
    frame_is_b = 1'b0;
  end
  // bounce: toggle each cycle, then settle
  task pin(input int idx, input logic lvl, input int ring);
    repeat (ring) begin
      @(posedge pclk);
      pins_q[idx] <= ~pins_q[idx];
    end
    @(posedge pclk);
    pins_q[idx] <= lvl;
  endtask : pin
  // type flipped after the pulse to expose misuse
  task frame(input logic rdo, input logic b);
    @(posedge pclk);
    frame_is_b <= b;
    if (rdo) frame_readout_start <= 1'b1;
    else frame_exposure_start <= 1'b1;
    @(posedge pclk);
    frame_exposure_start <= 1'b0;
    frame_readout_start <= 1'b0;
    frame_is_b <= ~b;
  endtask : frame
endmodule : trig_partner
`default_nettype wire

// ===== trigger_pulse_strobe_io.sv
`timescale 1ns/10ps
`default_nettype none
module trigger_pulse_strobe_io
  import trig_io_pkg::*;
#(
  parameter int TICK_CYCLES = US_TICK_CYCLES,
  parameter int PG_W = PG_WIDTH_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trigger_input_one,
  input wire logic ext_trigger_input_two,
  input wire logic grabber_control_line_one,
  input wire logic grabber_control_line_two,
  input wire logic frame_exposure_start,
  input wire logic frame_readout_start,
  input wire logic frame_is_b,
  output logic trigger_event,
  output logic trigger_targets_dual_video,
  output logic pulse_gen_running,
  output logic ext_output_one,
  output logic ext_output_two
);
  localparam int TCW = $clog2(TICK_CYCLES + 1);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

  // register state
  logic trig_en_q;
  logic [2:0] trig_src_q;
  logic trig_fall_q;
  logic [2:0] db_sel_q;
  logic trig_dual_q;
  logic [1:0] pg_gran_q;
  logic pg_counted_q;
  logic [15:0] pg_count_q;
  logic [PG_W-1:0] pg_period_q;
  logic [PG_W-1:0] pg_width_q;
  logic [1:0] stb_mode_q [2];
  logic stb_ref_q [2];
  logic [STB_W-1:0] stb_delay_q [2];
  logic [STB_W-1:0] stb_width_q [2];
  logic [7:0] out_map_q;

  // bus
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_hit;

  // trigger path
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [TCW-1:0] tick_cnt_q;
  logic us_tick_q;
  logic sel_raw;
  logic db_bypass;
  logic db_lvl_q;
  logic db_prev_q;
  logic [13:0] db_cnt_q;
  logic trig_edge;
  logic sw_fire;
  logic trig_event_q;

  // pulse generator
  logic pg_run_q;
  logic pg_q;
  logic [9:0] gran_cnt_q;
  logic gtick;
  logic [PG_W-1:0] per_cnt_q;
  logic [15:0] remain_q;
  logic pg_toggle;
  logic period_end;

  logic [1:0] strobe;
  logic [1:0] out_q;

  assign access = psel & penable;
  // a write lands on the one edge where pready is sampled high
  assign wr_en = access & pwrite & pready_q;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFS_TRIG_CTRL: begin
        rd_data[TC_EN] = trig_en_q;
        rd_data[TC_SRC +: 3] = trig_src_q;
        rd_data[TC_FALL] = trig_fall_q;
        rd_data[TC_DB +: 3] = db_sel_q;
        rd_data[TC_DUAL] = trig_dual_q;
      end
      OFS_COMMAND: rd_data = 32'h0000_0000;
      OFS_PG_CFG: begin
        rd_data[PG_GRAN +: 2] = pg_gran_q;
        rd_data[PG_COUNTED] = pg_counted_q;
        rd_data[PG_COUNT +: 16] = pg_count_q;
      end
      OFS_PG_PERIOD: rd_data[PG_W-1:0] = pg_period_q;
      OFS_PG_WIDTH: rd_data[PG_W-1:0] = pg_width_q;
      OFS_STATUS: begin
        rd_data[0] = pg_run_q; // R14
        rd_data[1] = db_lvl_q;
        rd_data[31:16] = remain_q;
      end
      OFS_OUT_MAP: rd_data[7:0] = out_map_q;
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < 2; i++) begin
          if (paddr == OFS_STB_BASE + 12'(i) * OFS_STB_STEP) begin
            rd_data[SC_MODE +: 2] = stb_mode_q[i];
            rd_data[SC_READOUT] = stb_ref_q[i];
            rd_hit = 1'b1;
          end
          if (paddr == OFS_STB_BASE + 12'(i) * OFS_STB_STEP + 12'h004) begin
            rd_data[STB_W-1:0] = stb_delay_q[i];
            rd_hit = 1'b1;
          end
          if (paddr == OFS_STB_BASE + 12'(i) * OFS_STB_STEP + 12'h008) begin
            rd_data[STB_W-1:0] = stb_width_q[i];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // one wait state: data and error are registered on the same edge that pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~rd_hit;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_en_q <= 1'b0;
      trig_src_q <= SRC_IN1;
      trig_fall_q <= 1'b0;
      db_sel_q <= DB_RESET_SEL; // R4
      trig_dual_q <= 1'b0;
      pg_gran_q <= 2'd0;
      pg_counted_q <= 1'b0;
      pg_count_q <= 16'd1;
      pg_period_q <= '0;
      pg_width_q <= '0;
      out_map_q <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        OFS_TRIG_CTRL: begin
          trig_en_q <= pwdata[TC_EN];
          trig_src_q <= pwdata[TC_SRC +: 3];
          trig_fall_q <= pwdata[TC_FALL];
          db_sel_q <= pwdata[TC_DB +: 3]; // R3
          trig_dual_q <= pwdata[TC_DUAL];
        end
        OFS_PG_CFG: begin
          pg_gran_q <= pwdata[PG_GRAN +: 2];
          pg_counted_q <= pwdata[PG_COUNTED];
          // R12
          if (pwdata[PG_COUNT +: 16] > PG_MAX_COUNT) begin
            pg_count_q <= PG_MAX_COUNT;
          end else if (pwdata[PG_COUNT +: 16] == 16'd0) begin
            pg_count_q <= 16'd1;
          end else begin
            pg_count_q <= pwdata[PG_COUNT +: 16];
          end
        end
        OFS_PG_PERIOD: pg_period_q <= pwdata[PG_W-1:0]; // R9
        OFS_PG_WIDTH: pg_width_q <= pwdata[PG_W-1:0]; // R10
        OFS_OUT_MAP: out_map_q <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // two strobe channels: config registers, generator and its link
  for (genvar g = 0; g < 2; g++) begin : g_stb
    strobe_if sif ();

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stb_mode_q[g] <= 2'd0;
        stb_ref_q[g] <= 1'b0;
        stb_delay_q[g] <= '0;
        stb_width_q[g] <= '0;
      end else if (wr_en) begin
        if (paddr == OFS_STB_BASE + 12'(g) * OFS_STB_STEP) begin
          stb_mode_q[g] <= pwdata[SC_MODE +: 2]; // R15
          stb_ref_q[g] <= pwdata[SC_READOUT]; // R16
        end
        if (paddr == OFS_STB_BASE + 12'(g) * OFS_STB_STEP + 12'h004) begin
          stb_delay_q[g] <= pwdata[STB_W-1:0]; // R17
        end
        if (paddr == OFS_STB_BASE + 12'(g) * OFS_STB_STEP + 12'h008) begin
          stb_width_q[g] <= pwdata[STB_W-1:0]; // R17
        end
      end
    end

    assign sif.mode = stb_mode_q[g];
    assign sif.ref_readout = stb_ref_q[g];
    assign sif.delay = stb_delay_q[g];
    assign sif.width = stb_width_q[g];
    assign sif.us_tick = us_tick_q;
    assign sif.exp_start = frame_exposure_start;
    assign sif.read_start = frame_readout_start;
    assign sif.frame_b = frame_is_b;
    assign strobe[g] = sif.strobe;

    strobe_gen u_strobe (
      .pclk(pclk),
      .presetn(presetn),
      .sb(sif.gen)
    );
  end

  // microsecond time base for debounce, pulses and strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      us_tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      us_tick_q <= 1'b1; // R21
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      us_tick_q <= 1'b0;
    end
  end

  assign pin_raw = {grabber_control_line_two, grabber_control_line_one,
                    ext_trigger_input_two, ext_trigger_input_one};

  for (genvar p = 0; p < 4; p++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_q[p] <= 1'b0;
        sync2_q[p] <= 1'b0;
      end else begin
        sync1_q[p] <= pin_raw[p];
        sync2_q[p] <= sync1_q[p];
      end
    end
  end

  always_comb begin
    case (trig_src_q) // R1
      SRC_IN1: sel_raw = sync2_q[0];
      SRC_IN2: sel_raw = sync2_q[1];
      SRC_CC1: sel_raw = sync2_q[2];
      SRC_CC2: sel_raw = sync2_q[3];
      SRC_PG: sel_raw = pg_q;
      default: sel_raw = 1'b0;
    endcase
  end

  // the internal generator is clean, so only pins are filtered
  assign db_bypass = (db_sel_q == DB_OFF) || (trig_src_q == SRC_PG) ||
                     (trig_src_q == SRC_SW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_lvl_q <= 1'b0;
      db_cnt_q <= 14'd0;
    end else if (db_bypass) begin
      db_lvl_q <= sel_raw;
      db_cnt_q <= 14'd0;
    end else if (sel_raw == db_lvl_q) begin
      db_cnt_q <= 14'd0; // R5
    end else if (us_tick_q) begin
      // new level must hold for the whole interval
      if (db_cnt_q + 14'd1 >= db_limit(db_sel_q)) begin // R21
        db_lvl_q <= sel_raw;
        db_cnt_q <= 14'd0;
      end else begin
        db_cnt_q <= db_cnt_q + 14'd1;
      end
    end
  end

  assign trig_edge = trig_fall_q ? (db_prev_q & ~db_lvl_q) :
                     (~db_prev_q & db_lvl_q); // R2
  assign sw_fire = wr_en && (paddr == OFS_COMMAND) && pwdata[CMD_SW] &&
                   (trig_src_q == SRC_SW); // R7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_prev_q <= 1'b0;
      trig_event_q <= 1'b0;
    end else begin
      db_prev_q <= db_lvl_q;
      trig_event_q <= trig_en_q & (trig_edge | sw_fire); // R6
    end
  end

  // pulse generator
  assign pg_toggle = wr_en && (paddr == OFS_COMMAND) && pwdata[CMD_PG_TOGGLE];
  assign gtick = us_tick_q && (gran_cnt_q == gran_div(pg_gran_q) - 10'd1); // R8
  // a zero period is run as one unit rather than stalling
  assign period_end = gtick && ((per_cnt_q + 1'b1 >= pg_period_q) ||
                                (pg_period_q == '0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_run_q <= 1'b0;
      gran_cnt_q <= 10'd0;
      per_cnt_q <= '0;
      remain_q <= 16'd0;
    end else if (pg_toggle) begin
      pg_run_q <= ~pg_run_q; // R13
      gran_cnt_q <= 10'd0;
      per_cnt_q <= '0;
      remain_q <= pg_count_q;
    end else if (pg_run_q) begin
      if (gtick) begin
        gran_cnt_q <= 10'd0;
      end else if (us_tick_q) begin
        gran_cnt_q <= gran_cnt_q + 10'd1;
      end
      if (period_end) begin
        per_cnt_q <= '0;
        if (pg_counted_q) begin
          remain_q <= remain_q - 16'd1;
          if (remain_q <= 16'd1) begin
            pg_run_q <= 1'b0; // R12
          end
        end // R11
      end else if (gtick) begin
        per_cnt_q <= per_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= pg_run_q && (per_cnt_q < pg_width_q); // R20
    end
  end

  // output mapping and polarity
  for (genvar o = 0; o < 2; o++) begin : g_out
    logic mapped;
    always_comb begin
      case (out_map_q[o*OM_STEP +: 3]) // R18
        MAP_MIRROR: mapped = db_lvl_q | trig_event_q;
        MAP_PG: mapped = pg_q;
        MAP_STB1: mapped = strobe[0];
        MAP_STB2: mapped = strobe[1];
        default: mapped = 1'b0;
      endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_q[o] <= 1'b0;
      end else begin
        out_q[o] <= mapped ^ out_map_q[o*OM_STEP + OM_POL]; // R19
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign trigger_event = trig_event_q;
  assign trigger_targets_dual_video = trig_dual_q;
  assign pulse_gen_running = pg_run_q;
  assign ext_output_one = out_q[0];
  assign ext_output_two = out_q[1];
endmodule : trigger_pulse_strobe_io
`default_nettype wire

// ===== trigger_pulse_strobe_io_bench.sv
`timescale 1ns/10ps
`default_nettype none
module trigger_pulse_strobe_io_bench;
  import trig_io_pkg::*;
  localparam int TK = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic trigger_event, trigger_targets_dual_video, pulse_gen_running;
  logic ext_output_one, ext_output_two, frame_is_b;
  logic ext_trigger_input_one, ext_trigger_input_two;
  logic grabber_control_line_one, grabber_control_line_two;
  logic frame_exposure_start, frame_readout_start;
  int errors, n_checks, ev_n, np, hi;
  trigger_pulse_strobe_io #(.TICK_CYCLES(TK)) i_dut (.*);
  trig_partner i_p (.*);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) if (trigger_event === 1'b1) ev_n <= ev_n + 1;
  task results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      errors++;
      results();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, "read");
  endtask : rd
  function automatic logic [31:0] tc(input int en, src, fall, db, dual);
    tc = {23'h0, dual[0], db[2:0], fall[0], src[2:0], en[0]};
  endfunction : tc
  task ev_chk(input int n, input int exp);
    int e0;
    e0 = ev_n;
    repeat (n) @(posedge pclk);
    chk(ev_n - e0, exp, "trig");
  endtask : ev_chk
  // ext_output_two is programmed active low in s_strobe, so watched inverted
  task watch(input bit o2, input int n);
    logic prev, cur;
    np = 0;
    hi = 0;
    prev = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      cur = o2 ? ~ext_output_two : ext_output_one;
      if (cur === 1'b1) hi++;
      if (cur === 1'b1 && prev !== 1'b1) np++;
      prev = cur;
    end
  endtask : watch
  task s_reset;
    rd(OFS_TRIG_CTRL, 32'h0000_0060);
    rd(OFS_PG_CFG, 32'h0001_0000);
    rd(OFS_COMMAND, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk(rerr, 1, "unmapped");
    wr(OFS_STATUS, 32'h1);
    chk(pulse_gen_running, 0, "ro");
    for (int d = 0; d < 8; d++) begin
      wr(OFS_TRIG_CTRL, tc(0, 0, 0, d, 0));
      rd(OFS_TRIG_CTRL, tc(0, 0, 0, d, 0));
    end
  endtask : s_reset
  task s_edges;
    for (int s = 0; s < 4; s++) for (int f = 0; f < 2; f++) begin
      wr(OFS_TRIG_CTRL, tc(1, s, f, 0, 0));
      i_p.pin(s, 1'b1, 0);
      ev_chk(12, f ? 0 : 1);
      i_p.pin(s, 1'b0, 0);
      ev_chk(12, f);
    end
  endtask : s_edges
  task s_debounce;
    wr(OFS_TRIG_CTRL, tc(1, 0, 0, 1, 0));
    i_p.pin(0, 1'b1, 5);
    ev_chk(30, 0);
    ev_chk(40, 1);
    i_p.pin(0, 1'b0, 0);
    ev_chk(80, 0);
    i_p.pin(0, 1'b1, 0);
    repeat (20) @(posedge pclk);
    i_p.pin(0, 1'b0, 0);
    ev_chk(80, 0);
    wr(OFS_TRIG_CTRL, tc(1, 0, 0, 2, 0));
    i_p.pin(0, 1'b1, 0);
    ev_chk(180, 0);
    ev_chk(60, 1);
    i_p.pin(0, 1'b0, 0);
    ev_chk(240, 0);
  endtask : s_debounce
  task s_enable;
    wr(OFS_TRIG_CTRL, tc(0, 1, 0, 0, 1));
    i_p.pin(1, 1'b1, 0);
    chk(trigger_targets_dual_video, 1, "dual");
    ev_chk(15, 0);
    i_p.pin(1, 1'b0, 0);
    ev_chk(15, 0);
  endtask : s_enable
  task s_sw;
    wr(OFS_TRIG_CTRL, tc(1, SRC_SW, 0, 0, 0));
    repeat (3) begin
      wr(OFS_COMMAND, 32'h1);
      ev_chk(4, 1);
    end
    wr(OFS_TRIG_CTRL, tc(1, SRC_IN1, 0, 0, 0));
    wr(OFS_COMMAND, 32'h1);
    ev_chk(8, 0);
  endtask : s_sw
  task s_pg;
    int m, e0;
    wr(OFS_OUT_MAP, 32'h2);
    wr(OFS_PG_PERIOD, 32'd2);
    wr(OFS_PG_WIDTH, 32'd1);
    for (int g = 0; g < 4; g++) begin
      m = 10 ** g;
      wr(OFS_PG_CFG, {16'd1, 13'h0, 1'b1, g[1:0]});
      wr(OFS_COMMAND, 32'h2);
      watch(0, 2 * m * TK + 20);
      chk(np, 1, "count");
      chk(hi >= m * TK - 2 && hi <= m * TK + TK + 2, 1, "gran");
      chk(pulse_gen_running, 0, "halt");
    end
    wr(OFS_PG_PERIOD, 32'd5);
    wr(OFS_PG_WIDTH, 32'd2);
    wr(OFS_PG_CFG, {16'd3, 13'h0, 1'b1, 2'b0});
    wr(OFS_COMMAND, 32'h2);
    watch(0, 200);
    chk(np, 3, "n3");
    wr(OFS_TRIG_CTRL, tc(1, SRC_PG, 0, 0, 0));
    wr(OFS_PG_CFG, 32'h0);
    e0 = ev_n;
    wr(OFS_COMMAND, 32'h2);
    watch(0, 200);
    chk(np >= 9 && np <= 11, 1, "period");
    chk(hi >= 72 && hi <= 88, 1, "width");
    chk(ev_n - e0 >= 9 && ev_n - e0 <= 11, 1, "pgtrig");
    chk(pulse_gen_running, 1, "run");
    wr(OFS_COMMAND, 32'h2);
    repeat (3) @(posedge pclk);
    watch(0, 60);
    chk(np, 0, "stopped");
    chk(pulse_gen_running, 0, "hold");
    rd(OFS_STATUS, 32'h0001_0000);
  endtask : s_pg
  task s_strobe;
    int e;
    wr(OFS_OUT_MAP, 32'hb4);
    wr(OFS_STB_BASE + 12'h004, 32'd3);
    wr(OFS_STB_BASE + 12'h008, 32'd5);
    wr(OFS_STB_BASE + OFS_STB_STEP, 32'h3);
    wr(OFS_STB_BASE + OFS_STB_STEP + 12'h008, 32'd2);
    for (int md = 0; md < 4; md++) for (int r = 0; r < 2; r++)
      for (int b = 0; b < 2; b++) for (int f = 0; f < 2; f++) begin
        wr(OFS_STB_BASE, {29'h0, r[0], md[1:0]});
        i_p.frame(f[0], b[0]);
        e = (r == f) && md[b];
        watch(1, 8);
        chk(hi, 0, "delay");
        watch(1, 50);
        chk(np, e, "fired");
        chk(hi >= 16 * e && hi <= 24 * e, 1, "swidth");
      end
    i_p.frame(1'b0, 1'b1);
    watch(0, 30);
    chk(np, 1, "stb2");
  endtask : s_strobe
  task s_mirror;
    wr(OFS_TRIG_CTRL, tc(1, SRC_CC2, 0, 0, 0));
    wr(OFS_OUT_MAP, 32'h81);
    i_p.pin(3, 1'b1, 0);
    repeat (8) @(posedge pclk);
    chk(ext_output_one, 1, "mir1");
    chk(ext_output_two, 1, "idle");
    i_p.pin(3, 1'b0, 0);
    repeat (8) @(posedge pclk);
    chk(ext_output_one, 0, "mir0");
  endtask : s_mirror
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    n_checks = 0;
    ev_n = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_edges;
    s_debounce;
    s_enable;
    s_sw;
    s_pg;
    s_strobe;
    s_mirror;
    results;
  end
endmodule : trigger_pulse_strobe_io_bench
`default_nettype wire

// ===== trigger_pulse_strobe_io_checker.sv
`timescale 1ns/10ps
`default_nettype none
module trigger_pulse_strobe_io_checker
  import trig_io_pkg::*;
#(
  parameter int TICK_CYCLES = US_TICK_CYCLES,
  parameter int PG_W = PG_WIDTH_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigger_event,
  input wire logic trigger_targets_dual_video,
  input wire logic pulse_gen_running,
  input wire logic ext_output_one
);
  logic wr_c;
  logic [8:0] ctrl_q;
  logic [3:0] om_q;
  assign wr_c = psel && penable && pready && pwrite && !pslverr;
  // shadows of programmed fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= 9'h060;
    else if (wr_c && paddr == OFS_TRIG_CTRL) ctrl_q <= pwdata[8:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) om_q <= 4'h0;
    else if (wr_c && paddr == OFS_OUT_MAP) om_q <= pwdata[3:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_PULSE:
    assert property (pready |=> !pready) else $error("pready long");
  AST_UNMAPPED_ERR:
    assert property (psel && penable && pready && paddr > OFS_OUT_MAP
      |-> pslverr && prdata == 32'h0) else $error("unmapped");
  AST_TRIG_SINGLE:
    assert property (trigger_event |=> !trigger_event)
      else $error("event long");
  AST_TRIG_ENABLED:
    assert property (trigger_event |-> ctrl_q[TC_EN] || $past(ctrl_q[TC_EN]))
      else $error("disabled");
  AST_DUAL_LEVEL:
    assert property (trigger_targets_dual_video == ctrl_q[TC_DUAL])
      else $error("dual");
  AST_SW_TRIG:
    assert property (wr_c && paddr == OFS_COMMAND && pwdata[CMD_SW]
      && ctrl_q[TC_EN] && ctrl_q[3:1] == SRC_SW |=> trigger_event)
      else $error("sw lost");
  AST_RUN_TOGGLE:
    assert property (wr_c && paddr == OFS_COMMAND && pwdata[CMD_PG_TOGGLE]
      |-> ##2 pulse_gen_running != $past(pulse_gen_running, 2))
      else $error("no toggle");
  AST_STATUS_RUN:
    assert property (psel && penable && pready && !pwrite
      && paddr == OFS_STATUS && $stable(pulse_gen_running)
      |-> prdata[0] == pulse_gen_running) else $error("status");
  AST_OUT_IDLE:
    assert property ($stable(om_q) && om_q[2:0] == MAP_NONE
      |-> ext_output_one == om_q[OM_POL]) else $error("idle");
endmodule : trigger_pulse_strobe_io_checker
bind trigger_pulse_strobe_io trigger_pulse_strobe_io_checker #(
  .TICK_CYCLES(TICK_CYCLES), .PG_W(PG_W)) i_chk (.*);
`default_nettype wire
